// ==== shared/drx_pkg.sv ====
// constants and types for the message-protocol receive error handler
package drx_pkg;

  // register byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_HDR_CNT = 8'h08;
  localparam logic [7:0] REG_PAY_CNT = 8'h0C;
  localparam logic [7:0] REG_SYNC = 8'h10;

  // control register fields
  localparam int CTRL_RX_EN_BIT = 0;
  localparam int CTRL_RBK_EN_BIT = 1;
  localparam int CTRL_PAR_EN_BIT = 2;
  localparam logic CTRL_RX_EN_RST = 1'b0;
  localparam logic CTRL_RBK_EN_RST = 1'b0;
  localparam logic CTRL_PAR_EN_RST = 1'b0;

  // status register fields
  localparam int STAT_CHK_BIT = 0;
  localparam int STAT_FRM_BIT = 1;
  localparam int STAT_PAR_BIT = 2;
  localparam int STAT_HUNT_BIT = 3;

  // sync register fields: first octet low, second octet high
  localparam int SYNC1_LSB = 0;
  localparam int SYNC2_LSB = 8;
  localparam logic [7:0] SYNC1_RST = 8'h96;
  localparam logic [7:0] SYNC2_RST = 8'h96;

  // header start characters of the three frame classes
  localparam logic [7:0] CLASS_DATA = 8'h81;
  localparam logic [7:0] CLASS_MAINT = 8'h90;
  localparam logic [7:0] CLASS_CTRL = 8'h05;

  // header layout after the class character
  localparam logic [2:0] HDR_BODY_LAST = 3'h4;
  localparam logic [2:0] HDR_COUNT_LO = 3'h0;
  localparam logic [2:0] HDR_COUNT_HI = 3'h1;
  localparam int COUNT_W = 14;
  localparam int COUNT_HI_W = 6;

  // 16-bit check sequence, reflected form of the HDLC generator
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  localparam int CNT_W = 16;
  localparam int BUF_W = 9;

  typedef enum logic [2:0] {
    ST_HUNT,
    ST_SYNC2,
    ST_CLASS,
    ST_HDR,
    ST_HCHK,
    ST_DATA,
    ST_PCHK
  } drx_state_t;

endpackage

// ==== tb/drx_rx_error_properties.sv ====
// port-level assertions for the receive error handler
`timescale 1ns/1ps
`default_nettype none

module drx_rx_error_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // character and buffer streams
  input wire logic ce_i,
  input wire logic char_valid_i,
  input wire logic char_ready_o,
  input wire logic buf_valid_o,
  input wire logic [7:0] buf_data_o,
  input wire logic buf_last_o,
  input wire logic buf_ready_i,
  // descriptor status
  input wire logic desc_valid_o,
  input wire logic desc_check_error_flag_o,
  input wire logic desc_framing_error_flag_o,
  input wire logic desc_parity_error_flag_o,
  input wire logic receive_block_event_o,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic mapped;
  assign mapped = reg_addr_i inside {drx_pkg::REG_CTRL, drx_pkg::REG_STATUS,
    drx_pkg::REG_HDR_CNT, drx_pkg::REG_PAY_CNT, drx_pkg::REG_SYNC};

  event_on_error_a: assert property (
    receive_block_event_o |-> desc_valid_o &&
      (desc_check_error_flag_o || desc_framing_error_flag_o))
    else $error("event without an errored close");
  close_after_take_a: assert property (
    desc_valid_o |-> $past(char_valid_i && char_ready_o && ce_i))
    else $error("close without a character taken");
  close_spacing_a: assert property (
    desc_valid_o |=> !desc_valid_o [*3])
    else $error("closes closer than a sync pair and class allow");
  flags_exclusive_a: assert property (
    desc_valid_o |-> !(desc_check_error_flag_o && desc_framing_error_flag_o))
    else $error("check and framing flags on one close");
  flags_hold_a: assert property (
    !desc_valid_o |-> $stable({desc_check_error_flag_o, desc_framing_error_flag_o,
      desc_parity_error_flag_o}))
    else $error("descriptor flags moved between closes");
  rdata_idle_a: assert property (
    !$past(reg_rd_i && ce_i) |-> reg_rdata_o == 32'h0)
    else $error("read data outside its cycle");
  rdata_unmapped_a: assert property (
    $past(reg_rd_i) && !$past(mapped) |-> reg_rdata_o == 32'h0)
    else $error("unmapped read returned data");
  ready_full_a: assert property (
    !char_ready_o |-> buf_valid_o)
    else $error("refused with an empty buffer");
  buf_hold_a: assert property (
    buf_valid_o && !buf_ready_i |=> buf_valid_o && $stable({buf_data_o, buf_last_o}))
    else $error("buffer head lost under stall");

  cover property (desc_valid_o && desc_check_error_flag_o);
  cover property (desc_valid_o && desc_framing_error_flag_o);
  cover property (receive_block_event_o);
  cover property (!char_ready_o);
endmodule

bind drx_rx_error drx_rx_error_properties chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .char_valid_i(char_valid_i), .char_ready_o(char_ready_o), .buf_valid_o(buf_valid_o),
  .buf_data_o(buf_data_o), .buf_last_o(buf_last_o), .buf_ready_i(buf_ready_i),
  .desc_valid_o(desc_valid_o), .desc_check_error_flag_o(desc_check_error_flag_o),
  .desc_framing_error_flag_o(desc_framing_error_flag_o),
  .desc_parity_error_flag_o(desc_parity_error_flag_o),
  .receive_block_event_o(receive_block_event_o), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
`default_nettype wire

// ==== tb/drx_station.sv ====
// remote station model offering queued characters on the link
`timescale 1ns/1ps
`default_nettype none

module drx_station (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pacing: one idle cycle after each character
  input wire logic slow_i,
  // character link
  input wire logic ready_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic stop_ok_o,
  output logic parity_ok_o
);
  // entries are {stop ok, parity ok, character}
  logic [9:0] q[$];

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      data_o <= 8'h00;
      stop_ok_o <= 1'b1;
      parity_ok_o <= 1'b1;
    end else if (!valid_o || ready_i) begin
      if (q.size() > 0 && !(valid_o && slow_i)) begin
        {stop_ok_o, parity_ok_o, data_o} <= q.pop_front();
        valid_o <= 1'b1;
      end else begin
        // idle line keeps toggling so no stale character looks valid
        valid_o <= 1'b0;
        data_o <= ~data_o;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/tb_drx_rx_error.sv ====
// self-checking bench for the receive error handler
`timescale 1ns/1ps
`default_nettype none

module tb_drx_rx_error;
  typedef struct {
    logic [7:0] cls;
    int cnt;
    logic hbad, pbad;
    int fidx, pidx;
    logic chk, frm, par;
    int dh, dp;
  } drx_row_t;

  logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, buf_ready_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic slow = 1'b0, stall = 1'b0, rbk_on = 1'b1, saw_full = 1'b0;
  logic [7:0] sync1 = drx_pkg::SYNC1_RST, sync2 = drx_pkg::SYNC2_RST;
  logic char_valid_i, char_stop_ok_i, char_parity_ok_i, char_ready_o, buf_valid_o, buf_last_o;
  logic desc_valid_o, desc_check_error_flag_o, desc_framing_error_flag_o;
  logic desc_parity_error_flag_o, receive_block_event_o;
  logic [7:0] char_data_i, buf_data_o;
  logic [31:0] reg_rdata_o, hc = 32'h0, pc = 32'h0;
  logic [8:0] got[$];
  logic [2:0] flags = 3'h0;
  int mismatches = 0, tests_run = 0, ndesc = 0, nrbk = 0, cyc = 0;

  drx_row_t rows[9] = '{
    '{drx_pkg::CLASS_CTRL, 0, 0, 0, -1, -1, 0, 0, 0, 0, 0},
    '{drx_pkg::CLASS_CTRL, 0, 1, 0, -1, -1, 1, 0, 0, 0, 1},
    '{drx_pkg::CLASS_DATA, 3, 0, 0, -1, -1, 0, 0, 0, 0, 0},
    '{drx_pkg::CLASS_DATA, 3, 1, 0, -1, -1, 1, 0, 0, 1, 0},
    '{drx_pkg::CLASS_CTRL, 0, 0, 0, -1, -1, 0, 0, 0, 0, 0},
    '{drx_pkg::CLASS_MAINT, 2, 0, 1, -1, -1, 1, 0, 0, 0, 1},
    '{drx_pkg::CLASS_DATA, 3, 0, 0, 4, -1, 0, 1, 0, 0, 0},
    '{drx_pkg::CLASS_MAINT, 2, 0, 0, -1, 9, 0, 0, 1, 0, 0},
    '{drx_pkg::CLASS_DATA, 1, 0, 0, 10, -1, 0, 1, 0, 0, 0}
  };

  drx_station stn (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .ready_i(char_ready_o),
    .valid_o(char_valid_i), .data_o(char_data_i), .stop_ok_o(char_stop_ok_i),
    .parity_ok_o(char_parity_ok_i));
  drx_rx_error dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .char_valid_i(char_valid_i),
    .char_data_i(char_data_i), .char_stop_ok_i(char_stop_ok_i),
    .char_parity_ok_i(char_parity_ok_i), .char_ready_o(char_ready_o),
    .buf_valid_o(buf_valid_o), .buf_data_o(buf_data_o), .buf_last_o(buf_last_o),
    .buf_ready_i(buf_ready_i), .desc_valid_o(desc_valid_o),
    .desc_check_error_flag_o(desc_check_error_flag_o),
    .desc_framing_error_flag_o(desc_framing_error_flag_o),
    .desc_parity_error_flag_o(desc_parity_error_flag_o),
    .receive_block_event_o(receive_block_event_o), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));

  initial forever #25 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    buf_ready_i <= !stall;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // sampled mid-cycle, where everything launched at the edge has settled
  always @(negedge clk_i) begin
    if (!rst_i) begin
      if (buf_valid_o && buf_ready_i) got.push_back({buf_last_o, buf_data_o});
      if (desc_valid_o) begin
        ndesc++;
        flags = {desc_check_error_flag_o, desc_framing_error_flag_o, desc_parity_error_flag_o};
      end
      nrbk += int'(receive_block_event_o);
      if (!char_ready_o) saw_full = 1'b1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, exp, "register read");
    @(posedge clk_i);
  endtask

  function automatic logic [15:0] fcs(input logic [7:0] b[$]);
    logic [15:0] c;
    c = drx_pkg::CRC_INIT;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ drx_pkg::CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction

  task automatic settle();
    for (int k = 0; k < 400 && (stn.q.size() > 0 || char_valid_i || buf_valid_o !== 1'b0); k++)
      @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask

  task automatic run_row(input drx_row_t r);
    logic [7:0] f[$], p[$];
    logic [15:0] c;
    int lim;
    f = {r.cls, 8'(r.cnt), 8'h00, 8'h11, 8'h22, 8'h33};
    c = fcs(f) ^ 16'(r.hbad);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    for (int i = 0; i < r.cnt; i++) p.push_back(8'(8'hA0 + i));
    c = fcs(p) ^ 16'(r.pbad);
    if (r.cnt > 0) f = {f, p, c[7:0], c[15:8]};
    lim = r.hbad ? 7 : (r.fidx >= 0 ? r.fidx : f.size() - 1);
    got.delete();
    ndesc = 0;
    nrbk = 0;
    stn.q.push_back({2'b11, drx_pkg::CLASS_DATA});
    stn.q.push_back({2'b11, sync1});
    stn.q.push_back({2'b11, sync2});
    foreach (f[i]) stn.q.push_back({i != r.fidx, i != r.fidx && i != r.pidx, f[i]});
    settle();
    check(32'(got.size()), 32'(lim + 1), "bytes written");
    foreach (got[i]) check(32'(got[i]), {23'h0, i == lim, f[i]}, "byte");
    check(32'(ndesc), 32'h1, "closes");
    check(32'(flags), {29'h0, r.chk, r.frm, r.par}, "flags");
    check(32'(nrbk), 32'(rbk_on & (r.chk | r.frm)), "event");
    hc = hc + 32'(r.dh);
    pc = pc + 32'(r.dp);
    rdchk(drx_pkg::REG_HDR_CNT, hc);
    rdchk(drx_pkg::REG_PAY_CNT, pc);
    rdchk(drx_pkg::REG_STATUS, {28'h0, 1'b1, r.par, r.frm, r.chk});
    wr(drx_pkg::REG_STATUS, 32'h7);
    $display("test done: class %h", r.cls);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check(32'(char_ready_o), 32'h1, "ready after reset");
    rdchk(drx_pkg::REG_CTRL, 32'h0);
    rdchk(drx_pkg::REG_STATUS, 32'h8);
    rdchk(drx_pkg::REG_SYNC, {16'h0, drx_pkg::SYNC2_RST, drx_pkg::SYNC1_RST});
    wr(8'h14, 32'hFFFF_FFFF);
    rdchk(8'h14, 32'h0);
    // receiver still off: a whole frame must vanish
    repeat (2) stn.q.push_back({2'b11, drx_pkg::SYNC1_RST});
    repeat (8) stn.q.push_back({2'b11, drx_pkg::CLASS_CTRL});
    settle();
    check(32'(got.size() + ndesc), 32'h0, "disabled receiver");
    $display("test done: reset and disabled");
    wr(drx_pkg::REG_CTRL, 32'h7);
    foreach (rows[i]) begin
      slow <= i[0];
      run_row(rows[i]);
    end
    wr(drx_pkg::REG_CTRL, 32'h3);
    run_row('{drx_pkg::CLASS_MAINT, 2, 0, 0, -1, 9, 0, 0, 0, 0, 0});
    wr(drx_pkg::REG_CTRL, 32'h5);
    rbk_on = 1'b0;
    run_row('{drx_pkg::CLASS_CTRL, 0, 1, 0, -1, -1, 1, 0, 0, 0, 1});
    rbk_on = 1'b1;
    wr(drx_pkg::REG_CTRL, 32'h7);
    wr(drx_pkg::REG_SYNC, 32'h0000_5AA5);
    sync1 = 8'hA5;
    sync2 = 8'h5A;
    wr(drx_pkg::REG_HDR_CNT, 32'h0000_FFFE);
    hc = 32'h0000_FFFE;
    saw_full = 1'b0;
    stall <= 1'b1;
    fork
      begin
        repeat (20) @(posedge clk_i);
        stall <= 1'b0;
      end
    join_none
    run_row('{drx_pkg::CLASS_DATA, 4, 1, 0, -1, -1, 1, 0, 0, 1, 0});
    check(32'(saw_full), 32'h1, "refused while stalled");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(drx_pkg::REG_HDR_CNT, 32'h0);
    rdchk(drx_pkg::REG_SYNC, 32'h0000_9696);
    $display("test done: second reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== verilog/drx_rx_error.sv ====
// receive framer with check-sequence and framing error handling
//
// Functional notes
// - header check mismatch stores check word, closes buffer, flags check error, event.
// - data/maintenance header check mismatch bumps header error count, then back to hunt.
// - header error on data/maintenance header hunts at once; later fake headers fail.
// - payload or control check mismatch stores word, closes, flags check error, event.
// - payload or control check mismatch bumps payload error count, then hunt.
// - a character after the class character without valid stop bit is reported as framing error.
// - framing error stores character, closes buffer, flags framing error, event.
// - parity is not checked on a character that has a framing error.
// - all check sequences use the 16-bit HDLC generator polynomial.
// - frames open with two sync octets and close with a check sequence.
`timescale 1ns/1ps
`default_nettype none

module drx_rx_error (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // character stream from the deserializer
  input wire logic char_valid_i,
  input wire logic [7:0] char_data_i,
  input wire logic char_stop_ok_i,
  input wire logic char_parity_ok_i,
  output logic char_ready_o,
  // bytes to the receive buffer
  output logic buf_valid_o,
  output logic [7:0] buf_data_o,
  output logic buf_last_o,
  input wire logic buf_ready_i,
  // buffer descriptor status
  output logic desc_valid_o,
  output logic desc_check_error_flag_o,
  output logic desc_framing_error_flag_o,
  output logic desc_parity_error_flag_o,
  output logic receive_block_event_o,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);

  typedef struct packed {
    drx_pkg::drx_state_t st;
    logic [2:0] idx;
    logic [drx_pkg::COUNT_W-1:0] remain;
    logic [15:0] crc;
    logic [7:0] chk_lo;
    logic is_ctrl;
    logic par_err;
    logic rx_en;
    logic rbk_en;
    logic par_en;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [drx_pkg::CNT_W-1:0] header_check_error_count;
    logic [drx_pkg::CNT_W-1:0] payload_check_error_count;
    logic stat_chk;
    logic stat_frm;
    logic stat_par;
    logic [31:0] rdata;
    logic desc_valid;
    logic desc_chk;
    logic desc_frm;
    logic desc_par;
    logic receive_block_event;
  } drx_regs_t;

  drx_regs_t s_reg;
  drx_regs_t s_next;

  logic buf_in_ready;
  logic wr_valid;
  logic [7:0] wr_data;
  logic wr_last;
  logic take;
  logic close;
  logic close_chk;
  logic close_frm;
  logic hdr_err;
  logic pay_err;
  logic par_bad;
  logic [15:0] rx_word;
  logic is_class;

  // one byte through the reflected check generator
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ drx_pkg::CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

  // check word is sent complemented, low octet first
  function automatic logic chk_ok(input logic [15:0] crc, input logic [15:0] word);
    return word == ~crc;
  endfunction

  function automatic logic is_start(input logic [7:0] d);
    return (d == drx_pkg::CLASS_DATA) || (d == drx_pkg::CLASS_MAINT) ||
           (d == drx_pkg::CLASS_CTRL);
  endfunction

  drx_skid_buf #(
    .W(drx_pkg::BUF_W)
  ) u_buf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(wr_valid),
    .in_data_i({wr_last, wr_data}),
    .in_ready_o(buf_in_ready),
    .out_valid_o(buf_valid_o),
    .out_data_o({buf_last_o, buf_data_o}),
    .out_ready_i(buf_ready_i)
  );

  always_comb begin
    s_next = s_reg;
    wr_valid = 1'b0;
    wr_data = char_data_i;
    wr_last = 1'b0;
    close = 1'b0;
    close_chk = 1'b0;
    close_frm = 1'b0;
    hdr_err = 1'b0;
    pay_err = 1'b0;
    // a stalled buffer holds the character source off, so nothing is dropped
    take = char_valid_i && buf_in_ready;
    rx_word = {char_data_i, s_reg.chk_lo};
    is_class = is_start(char_data_i);
    par_bad = s_reg.par_en && char_stop_ok_i && !char_parity_ok_i;

    s_next.desc_valid = 1'b0;
    s_next.receive_block_event = 1'b0;
    s_next.rdata = '0;

    if (take && !s_reg.rx_en) begin
      s_next.st = drx_pkg::ST_HUNT;
    end else if (take) begin
      case (s_reg.st)
        drx_pkg::ST_HUNT: begin
          if (char_stop_ok_i && char_data_i == s_reg.sync1) begin
            s_next.st = drx_pkg::ST_SYNC2;
          end
        end
        drx_pkg::ST_SYNC2: begin
          if (!char_stop_ok_i) begin
            s_next.st = drx_pkg::ST_HUNT;
          end else if (char_data_i == s_reg.sync2) begin
            s_next.st = drx_pkg::ST_CLASS;
          end else if (char_data_i != s_reg.sync1) begin
            s_next.st = drx_pkg::ST_HUNT;
          end
        end
        drx_pkg::ST_CLASS: begin
          if (char_stop_ok_i && is_class) begin
            // frame opens with the class character
            wr_valid = 1'b1;
            s_next.st = drx_pkg::ST_HDR;
            s_next.idx = '0;
            s_next.crc = crc_byte(drx_pkg::CRC_INIT, char_data_i);
            s_next.is_ctrl = (char_data_i == drx_pkg::CLASS_CTRL);
            s_next.par_err = par_bad;
          end else if (char_stop_ok_i && char_data_i == s_reg.sync2) begin
            s_next.st = drx_pkg::ST_CLASS;
          end else if (char_stop_ok_i && char_data_i == s_reg.sync1) begin
            s_next.st = drx_pkg::ST_SYNC2;
          end else begin
            s_next.st = drx_pkg::ST_HUNT;
          end
        end
        drx_pkg::ST_HDR: begin
          wr_valid = 1'b1;
          s_next.crc = crc_byte(s_reg.crc, char_data_i);
          s_next.idx = s_reg.idx + 3'h1;
          if (s_reg.idx == drx_pkg::HDR_COUNT_LO) begin
            s_next.remain[7:0] = char_data_i;
          end
          if (s_reg.idx == drx_pkg::HDR_COUNT_HI) begin
            s_next.remain[drx_pkg::COUNT_W-1:8] = char_data_i[drx_pkg::COUNT_HI_W-1:0];
          end
          if (s_reg.idx == drx_pkg::HDR_BODY_LAST) begin
            s_next.st = drx_pkg::ST_HCHK;
            s_next.idx = '0;
          end
        end
        drx_pkg::ST_HCHK: begin
          wr_valid = 1'b1;
          if (s_reg.idx == 3'h0) begin
            s_next.chk_lo = char_data_i;
            s_next.idx = 3'h1;
          end else if (!chk_ok(s_reg.crc, rx_word)) begin
            // control frames end here, so their error counts as payload error
            close = 1'b1;
            close_chk = 1'b1;
            hdr_err = !s_reg.is_ctrl;
            pay_err = s_reg.is_ctrl;
            s_next.st = drx_pkg::ST_HUNT;
          end else if (s_reg.is_ctrl || s_reg.remain == '0) begin
            close = 1'b1;
            s_next.st = drx_pkg::ST_HUNT;
          end else begin
            s_next.st = drx_pkg::ST_DATA;
            s_next.crc = drx_pkg::CRC_INIT;
          end
        end
        drx_pkg::ST_DATA: begin
          // sync-like octets in payload are plain data while the count runs
          wr_valid = 1'b1;
          s_next.crc = crc_byte(s_reg.crc, char_data_i);
          s_next.remain = s_reg.remain - 1'b1;
          if (s_reg.remain == {{(drx_pkg::COUNT_W-1){1'b0}}, 1'b1}) begin
            s_next.st = drx_pkg::ST_PCHK;
            s_next.idx = '0;
          end
        end
        drx_pkg::ST_PCHK: begin
          wr_valid = 1'b1;
          if (s_reg.idx == 3'h0) begin
            s_next.chk_lo = char_data_i;
            s_next.idx = 3'h1;
          end else begin
            close = 1'b1;
            close_chk = !chk_ok(s_reg.crc, rx_word);
            pay_err = close_chk;
            s_next.st = drx_pkg::ST_HUNT;
          end
        end
        default: begin
          s_next.st = drx_pkg::ST_HUNT;
        end
      endcase

      // in-frame character without a stop bit overrides whatever the state decided
      if (s_reg.st inside {drx_pkg::ST_HDR, drx_pkg::ST_HCHK, drx_pkg::ST_DATA,
                           drx_pkg::ST_PCHK} && !char_stop_ok_i) begin
        wr_valid = 1'b1;
        close = 1'b1;
        close_chk = 1'b0;
        close_frm = 1'b1;
        hdr_err = 1'b0;
        pay_err = 1'b0;
        s_next.st = drx_pkg::ST_HUNT;
      end else if (wr_valid && s_reg.st != drx_pkg::ST_CLASS && par_bad) begin
        s_next.par_err = 1'b1;
      end
    end

    wr_last = close;

    if (close) begin
      s_next.desc_valid = 1'b1;
      s_next.desc_chk = close_chk;
      s_next.desc_frm = close_frm;
      s_next.desc_par = s_next.par_err;
      // block event only for errored closes, and only when enabled
      s_next.receive_block_event = s_reg.rbk_en && (close_chk || close_frm);
    end

    // register writes; hardware sets win over software clears
    if (reg_wr_i) begin
      case (reg_addr_i)
        drx_pkg::REG_CTRL: begin
          s_next.rx_en = reg_wdata_i[drx_pkg::CTRL_RX_EN_BIT];
          s_next.rbk_en = reg_wdata_i[drx_pkg::CTRL_RBK_EN_BIT];
          s_next.par_en = reg_wdata_i[drx_pkg::CTRL_PAR_EN_BIT];
        end
        drx_pkg::REG_STATUS: begin
          if (reg_wdata_i[drx_pkg::STAT_CHK_BIT]) begin
            s_next.stat_chk = 1'b0;
          end
          if (reg_wdata_i[drx_pkg::STAT_FRM_BIT]) begin
            s_next.stat_frm = 1'b0;
          end
          if (reg_wdata_i[drx_pkg::STAT_PAR_BIT]) begin
            s_next.stat_par = 1'b0;
          end
        end
        drx_pkg::REG_HDR_CNT: begin
          s_next.header_check_error_count = reg_wdata_i[drx_pkg::CNT_W-1:0];
        end
        drx_pkg::REG_PAY_CNT: begin
          s_next.payload_check_error_count = reg_wdata_i[drx_pkg::CNT_W-1:0];
        end
        drx_pkg::REG_SYNC: begin
          s_next.sync1 = reg_wdata_i[drx_pkg::SYNC1_LSB +: 8];
          s_next.sync2 = reg_wdata_i[drx_pkg::SYNC2_LSB +: 8];
        end
        default: begin
        end
      endcase
    end

    // an increment in the cycle of a software load counts on top of the loaded value
    if (hdr_err) begin
      s_next.header_check_error_count = s_next.header_check_error_count + 1'b1;
    end
    if (pay_err) begin
      s_next.payload_check_error_count = s_next.payload_check_error_count + 1'b1;
    end
    if (close && close_chk) begin
      s_next.stat_chk = 1'b1;
    end
    if (close && close_frm) begin
      s_next.stat_frm = 1'b1;
    end
    if (close && s_next.par_err) begin
      s_next.stat_par = 1'b1;
    end

    if (reg_rd_i) begin
      case (reg_addr_i)
        drx_pkg::REG_CTRL: begin
          s_next.rdata[drx_pkg::CTRL_RX_EN_BIT] = s_reg.rx_en;
          s_next.rdata[drx_pkg::CTRL_RBK_EN_BIT] = s_reg.rbk_en;
          s_next.rdata[drx_pkg::CTRL_PAR_EN_BIT] = s_reg.par_en;
        end
        drx_pkg::REG_STATUS: begin
          s_next.rdata[drx_pkg::STAT_CHK_BIT] = s_reg.stat_chk;
          s_next.rdata[drx_pkg::STAT_FRM_BIT] = s_reg.stat_frm;
          s_next.rdata[drx_pkg::STAT_PAR_BIT] = s_reg.stat_par;
          s_next.rdata[drx_pkg::STAT_HUNT_BIT] = (s_reg.st == drx_pkg::ST_HUNT);
        end
        drx_pkg::REG_HDR_CNT: begin
          s_next.rdata[drx_pkg::CNT_W-1:0] = s_reg.header_check_error_count;
        end
        drx_pkg::REG_PAY_CNT: begin
          s_next.rdata[drx_pkg::CNT_W-1:0] = s_reg.payload_check_error_count;
        end
        drx_pkg::REG_SYNC: begin
          s_next.rdata[drx_pkg::SYNC1_LSB +: 8] = s_reg.sync1;
          s_next.rdata[drx_pkg::SYNC2_LSB +: 8] = s_reg.sync2;
        end
        default: begin
          s_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.st <= drx_pkg::ST_HUNT;
      s_reg.crc <= drx_pkg::CRC_INIT;
      s_reg.rx_en <= drx_pkg::CTRL_RX_EN_RST;
      s_reg.rbk_en <= drx_pkg::CTRL_RBK_EN_RST;
      s_reg.par_en <= drx_pkg::CTRL_PAR_EN_RST;
      s_reg.sync1 <= drx_pkg::SYNC1_RST;
      s_reg.sync2 <= drx_pkg::SYNC2_RST;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ready is the buffer's not-full (room) flag, itself a flip-flop
  assign char_ready_o = buf_in_ready;
  assign desc_valid_o = s_reg.desc_valid;
  assign desc_check_error_flag_o = s_reg.desc_chk;
  assign desc_framing_error_flag_o = s_reg.desc_frm;
  assign desc_parity_error_flag_o = s_reg.desc_par;
  assign receive_block_event_o = s_reg.receive_block_event;
  assign reg_rdata_o = s_reg.rdata;

endmodule

`default_nettype wire

// ==== verilog/drx_skid_buf.sv ====
// two-entry valid/ready buffer between the receiver and buffer memory
`timescale 1ns/1ps
`default_nettype none

module drx_skid_buf #(
  parameter int W = 9
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);

  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] count;
    logic room;
    logic avail;
  } drx_buf_t;

  drx_buf_t s_reg;
  drx_buf_t s_next;
  logic push;
  logic pop;

  always_comb begin
    s_next = s_reg;
    push = in_valid_i && (s_reg.count != 2'h2);
    pop = out_ready_i && (s_reg.count != 2'h0);
    if (pop) begin
      s_next.head = s_reg.tail;
    end
    if (push) begin
      if (s_reg.count == 2'h0 || (s_reg.count == 2'h1 && pop)) begin
        s_next.head = in_data_i;
      end else begin
        s_next.tail = in_data_i;
      end
    end
    s_next.count = s_reg.count + {1'b0, push} - {1'b0, pop};
    // flags kept as flops so the top-level outputs need no gate after them
    s_next.room = (s_next.count != 2'h2);
    s_next.avail = (s_next.count != 2'h0);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.room <= 1'b1;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // ready is full-based only, so it never depends on the drain side in the same cycle
  assign in_ready_o = s_reg.room;
  assign out_valid_o = s_reg.avail;
  assign out_data_o = s_reg.head;

endmodule

`default_nettype wire
